/* logic/rcw_pkg.sv */
// Constants, register map and state type of the reset control and wake notification block
// Overview of operation
// - Protocol core reset bit holds core in reset, self-clears once core is out.
// - Port B PHY reset bit holds PHY reset at least 102 us, then self-clears.
// - Port A PHY reset bit holds PHY reset at least 102 us, then self-clears.
// - Digital reset bit resets all but PHYs, keeps protected bits, self-clears.
// - Writes to a self-clearing reset bit are ignored while it is set.
// - Reset control register stays readable in any state, never stalls the bus.
// - Partial reads allowed; no double-word grouping on this register.
// - PHY in energy-detect power-down resumes on cable energy, raises energy flag.
// - Energy already present when power-down is enabled is reported at once.
// - Unmasked PHY interrupts show in status bit 26 (A) and 27 (B).
// - Each status bit drives the interrupt pin when its enable is set.
// - Any port PHY interrupt sets that port's wake status.
// - PHY detects DA, broadcast, magic and wakeup frames, raises wake-on-LAN flag.
// - Port wake status bits stay latched after the PHY event ends.
// - Wake status ANDed with port enable, ORed into wake event status bit.
// - Wake event status ANDed with its enable, ORed into the interrupt pin.
// - Wake event status is set regardless of its interrupt enable.
// - With auto-wake set, a wake event requests exit from low power.
// - A gated module clock freezes the module without resetting it.
// - After digital reset, reload EEPROM configuration; straps are not re-latched.
package rcw_pkg;

  // Register byte addresses
  localparam logic [11:0] OFS_SOFTWARE_RESET_CONTROL  = 12'h1F8;
  localparam logic [11:0] OFS_PWR_MGMT   = 12'h084;
  localparam logic [11:0] OFS_INT_STATUS = 12'h058;
  localparam logic [11:0] OFS_INT_ENABLE = 12'h05C;
  localparam logic [11:0] OFS_PHY_CTL    = 12'h1C0;
  localparam logic [11:0] OFS_PHY_FLAGS  = 12'h1C4;

  // Reset control bit positions
  localparam int BIT_DIGITAL_RST = 0;
  localparam int BIT_PORT_A_RST  = 1;
  localparam int BIT_PORT_B_RST  = 2;
  localparam int BIT_CORE_RST    = 6;

  // Interrupt status bit positions
  localparam int BIT_INT_OTHER   = 0;
  localparam int BIT_INT_WAKE    = 17;
  localparam int BIT_INT_PHY_A   = 26;
  localparam int BIT_INT_PHY_B   = 27;
  localparam logic [31:0] INT_EN_MASK = 32'h0C02_0001;

  // Power management bit positions
  localparam int BIT_PM_READY     = 0;
  localparam int BIT_PM_AUTO_WAKE = 1;
  localparam int BIT_AUTO_WAKE_ENABLE_EN   = 2;  // Two bits, port A then B
  localparam int BIT_AUTO_WAKE_ENABLE_STS  = 4;  // Two bits, port A then B
  localparam int BIT_PM_CORE_CLK  = 6;

  // PHY control byte per port: wake frame types, power-down enable, masks
  localparam int BIT_PC_WOL_TYPES = 0;  // Four bits: DA, broadcast, magic, wakeup frame
  localparam int BIT_PC_EDPD_EN   = 4;
  localparam int BIT_PC_MASK      = 5;  // Three bits, one per source flag
  localparam int FLG_ENERGY = 0;
  localparam int FLG_WOL    = 1;
  localparam int FLG_OTHER  = 2;

  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PHY_RST_MIN_NS   = 102000;
  localparam int CORE_RST_MIN_NS  = 1000;
  localparam int DIG_RST_MIN_NS   = 1000;
  localparam int PHY_RST_CYC  = (PHY_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CORE_RST_CYC = (CORE_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIG_RST_CYC  = (DIG_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW = 14;

  // Whole block state
  typedef struct packed {
    logic [1:0][CW-1:0] phy_cnt;
    logic [CW-1:0]      core_cnt;
    logic [CW-1:0]      dig_cnt;
    logic [1:0]         phy_rst;
    logic               core_rst;
    logic               core_wait;
    logic               dig_rst;
    logic [1:0][7:0]    phy_ctl;
    logic [1:0][2:0]    src_flg;
    logic [1:0]         edpd_prev;
    logic [1:0]         phy_pd;
    logic               auto_wake;
    logic [1:0]         wake_en;
    logic [1:0]         wake_sts;
    logic               core_clk_off;
    logic [31:0]        int_en;
    logic               irq;
    logic               wake_req;
    logic               strap_done;
    logic               strap_latch;
    logic               eeprom_reload;
    logic [31:0]        rdata;
  } rcw_state_s;

endpackage

/* logic/rcw_top.sv */
// Software resets, PHY event flags and wake notification logic
//
// Our own choice: the address-and-strobe port.
module rcw_top import rcw_pkg::*; #(
  parameter int unsigned P_PHY_RST_CYC = PHY_RST_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_core_ready,
  input  wire logic        i_low_power,
  input  wire logic        i_other_irq,
  input  wire logic [1:0]  i_energy_present,
  input  wire logic [7:0]  i_wol_match,
  input  wire logic [1:0]  i_phy_event,
  output logic             o_core_rst,
  output logic      [1:0]  o_phy_rst,
  output logic             o_digital_rst,
  output logic             o_eeprom_reload,
  output logic             o_strap_latch,
  output logic      [1:0]  o_phy_powered_down,
  output logic             o_core_clk_en,
  output logic             o_wake_request,
  output logic             o_irq
);

  rcw_state_s s_reg;
  rcw_state_s s_next;

  logic [1:0]  phy_int;
  logic        wake_evt;
  logic [31:0] interrupt_status;
  logic        wr_rst;
  logic        wr_pm;

  // Combined interrupt view from current state
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      phy_int[p] = |(s_reg.src_flg[p] & s_reg.phy_ctl[p][BIT_PC_MASK +: 3]);
    end
    wake_evt = |(s_reg.wake_sts & s_reg.wake_en);
    interrupt_status = 32'h0000_0000;
    interrupt_status[BIT_INT_OTHER] = i_other_irq;
    interrupt_status[BIT_INT_WAKE]  = wake_evt;
    interrupt_status[BIT_INT_PHY_A] = phy_int[0];
    interrupt_status[BIT_INT_PHY_B] = phy_int[1];
    wr_rst = i_wr && (i_addr == OFS_SOFTWARE_RESET_CONTROL);
    wr_pm  = i_wr && (i_addr == OFS_PWR_MGMT);
  end

  // Next state: resets, PHY flags, wake latches, registers
  always_comb begin
    logic [1:0] rst_bit;
    logic       en_now;
    logic       clr;
    logic [1:0][2:0] flg_set;
    rst_bit = '0;
    en_now  = 1'b0;
    clr     = 1'b0;
    flg_set = '0;
    s_next  = s_reg;
    s_next.strap_latch   = 1'b0;
    s_next.eeprom_reload = 1'b0;
    s_next.wake_req      = 1'b0;
    rst_bit[0] = i_wdata[BIT_PORT_A_RST];
    rst_bit[1] = i_wdata[BIT_PORT_B_RST];

    // Straps are caught once, only after the chip reset
    if (!s_reg.strap_done) begin
      s_next.strap_done  = 1'b1;
      s_next.strap_latch = 1'b1;
    end

    // Per-port PHY reset, event flags and power-down
    for (int p = 0; p < 2; p++) begin
      if (s_reg.phy_rst[p]) begin
        // Minimum hold counted from the set, then bit and pin drop together
        if (s_reg.phy_cnt[p] == CW'(P_PHY_RST_CYC - 1)) begin
          s_next.phy_rst[p] = 1'b0;
        end else begin
          s_next.phy_cnt[p] = s_reg.phy_cnt[p] + CW'(1);
        end
        s_next.phy_ctl[p]   = '0;
        s_next.src_flg[p]   = '0;
        s_next.phy_pd[p]    = 1'b0;
        s_next.edpd_prev[p] = 1'b0;
      end else begin
        en_now = s_reg.phy_ctl[p][BIT_PC_EDPD_EN];
        s_next.edpd_prev[p] = en_now;
        if (!en_now) begin
          s_next.phy_pd[p] = 1'b0;
        end else if (!s_reg.edpd_prev[p]) begin
          // Carrier already there at enable: detect now, stay up
          s_next.phy_pd[p] = !i_energy_present[p];
          if (i_energy_present[p]) begin
            s_next.src_flg[p][FLG_ENERGY] = 1'b1;
            flg_set[p][FLG_ENERGY] = 1'b1;
          end
        end else if (s_reg.phy_pd[p] && i_energy_present[p]) begin
          s_next.phy_pd[p] = 1'b0;
          s_next.src_flg[p][FLG_ENERGY] = 1'b1;
          flg_set[p][FLG_ENERGY] = 1'b1;
        end else if (!i_energy_present[p]) begin
          s_next.phy_pd[p] = 1'b1;
        end
        if (|(i_wol_match[4*p +: 4] & s_reg.phy_ctl[p][BIT_PC_WOL_TYPES +: 4])) begin
          s_next.src_flg[p][FLG_WOL] = 1'b1;
          flg_set[p][FLG_WOL] = 1'b1;
        end
        if (i_phy_event[p]) begin
          s_next.src_flg[p][FLG_OTHER] = 1'b1;
          flg_set[p][FLG_OTHER] = 1'b1;
        end
      end
      // Wake status: clear by write-one, a new event wins over the clear
      clr = wr_pm && i_wdata[BIT_AUTO_WAKE_ENABLE_STS + p];
      if (clr) begin
        s_next.wake_sts[p] = 1'b0;
      end
      if (phy_int[p]) begin
        s_next.wake_sts[p] = 1'b1;
      end
    end

    // Protocol core reset: hold, release, then wait for core to come up
    if (s_reg.core_rst && !s_reg.core_wait) begin
      if (s_reg.core_cnt == CW'(CORE_RST_CYC - 1)) begin
        s_next.core_wait = 1'b1;
      end else begin
        s_next.core_cnt = s_reg.core_cnt + CW'(1);
      end
    end else if (s_reg.core_rst && i_core_ready) begin
      s_next.core_rst  = 1'b0;
      s_next.core_wait = 1'b0;
    end

    // Register writes; PHY flags are write-one-to-clear after setting above
    if (i_wr) begin
      case (i_addr)
        OFS_SOFTWARE_RESET_CONTROL: begin
          // Set-only while clear; writes to a set bit do nothing
          for (int p = 0; p < 2; p++) begin
            if (!s_reg.phy_rst[p] && rst_bit[p]) begin
              s_next.phy_rst[p] = 1'b1;
              s_next.phy_cnt[p] = '0;
            end
          end
          if (!s_reg.core_rst && i_wdata[BIT_CORE_RST]) begin
            s_next.core_rst  = 1'b1;
            s_next.core_cnt  = '0;
            s_next.core_wait = 1'b0;
          end
          if (!s_reg.dig_rst && i_wdata[BIT_DIGITAL_RST]) begin
            s_next.dig_rst = 1'b1;
            s_next.dig_cnt = '0;
          end
        end
        OFS_PWR_MGMT: begin
          s_next.auto_wake    = i_wdata[BIT_PM_AUTO_WAKE];
          s_next.wake_en      = i_wdata[BIT_AUTO_WAKE_ENABLE_EN +: 2];
          s_next.core_clk_off = i_wdata[BIT_PM_CORE_CLK];
        end
        OFS_INT_ENABLE: begin
          s_next.int_en = i_wdata & INT_EN_MASK;
        end
        OFS_PHY_CTL: begin
          for (int p = 0; p < 2; p++) begin
            if (!s_reg.phy_rst[p]) begin
              s_next.phy_ctl[p] = i_wdata[8*p +: 8];
            end
          end
        end
        OFS_PHY_FLAGS: begin
          for (int p = 0; p < 2; p++) begin
            // A flag raised in this cycle survives its own clear
            s_next.src_flg[p] = (s_next.src_flg[p] & ~i_wdata[8*p +: 3]) | flg_set[p];
          end
        end
        default: begin
        end
      endcase
    end

    // Digital reset: clears all but the PHY side and protected bits
    if (s_reg.dig_rst) begin
      s_next.int_en    = '0;
      s_next.wake_sts  = '0;
      s_next.core_rst  = 1'b0;
      s_next.core_wait = 1'b0;
      s_next.core_cnt  = '0;
      if (s_reg.dig_cnt == CW'(DIG_RST_CYC - 1)) begin
        s_next.dig_rst       = 1'b0;
        s_next.eeprom_reload = 1'b1;
      end else begin
        s_next.dig_cnt = s_reg.dig_cnt + CW'(1);
      end
    end

    // Interrupt pin and automatic wake
    s_next.irq      = |(interrupt_status & s_reg.int_en);
    s_next.wake_req = s_reg.auto_wake && wake_evt && i_low_power;

    // Read data, answered in any state without stalling
    s_next.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        OFS_SOFTWARE_RESET_CONTROL: begin
          s_next.rdata[BIT_DIGITAL_RST] = s_reg.dig_rst;
          s_next.rdata[BIT_PORT_A_RST]  = s_reg.phy_rst[0];
          s_next.rdata[BIT_PORT_B_RST]  = s_reg.phy_rst[1];
          s_next.rdata[BIT_CORE_RST]    = s_reg.core_rst;
        end
        OFS_PWR_MGMT: begin
          s_next.rdata[BIT_PM_READY]         = !s_reg.dig_rst && !i_low_power;
          s_next.rdata[BIT_PM_AUTO_WAKE]     = s_reg.auto_wake;
          s_next.rdata[BIT_AUTO_WAKE_ENABLE_EN +: 2]  = s_reg.wake_en;
          s_next.rdata[BIT_AUTO_WAKE_ENABLE_STS +: 2] = s_reg.wake_sts;
          s_next.rdata[BIT_PM_CORE_CLK]      = s_reg.core_clk_off;
        end
        OFS_INT_STATUS: s_next.rdata = interrupt_status;
        OFS_INT_ENABLE: s_next.rdata = s_reg.int_en;
        OFS_PHY_CTL:    s_next.rdata = {16'h0000, s_reg.phy_ctl[1], s_reg.phy_ctl[0]};
        OFS_PHY_FLAGS: begin
          s_next.rdata[2:0]  = s_reg.src_flg[0];
          s_next.rdata[10:8] = s_reg.src_flg[1];
        end
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign o_rdata            = s_reg.rdata;
  assign o_core_rst         = s_reg.core_rst && !s_reg.core_wait;
  assign o_phy_rst          = s_reg.phy_rst;
  assign o_digital_rst      = s_reg.dig_rst;
  assign o_eeprom_reload    = s_reg.eeprom_reload;
  assign o_strap_latch      = s_reg.strap_latch;
  assign o_phy_powered_down = s_reg.phy_pd;
  // Gating only freezes the core; its state survives, no reset applied
  assign o_core_clk_en      = !s_reg.core_clk_off;
  assign o_wake_request     = s_reg.wake_req;
  assign o_irq              = s_reg.irq;

  // Helper counters of how long each PHY reset pin has stood high
  logic [15:0] hold_a;
  logic [15:0] hold_b;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      hold_a <= 16'h0000;
      hold_b <= 16'h0000;
    end else begin
      hold_a <= o_phy_rst[0] ? hold_a + 16'h0001 : 16'h0000;
      hold_b <= o_phy_rst[1] ? hold_b + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence s_core_write;
    i_wr && (i_addr == OFS_SOFTWARE_RESET_CONTROL) && i_wdata[BIT_CORE_RST] && !s_reg.core_rst;
  endsequence
  sequence s_core_up;
    !o_core_rst && i_core_ready;
  endsequence

  property p_phy_a_hold;
    $fell(o_phy_rst[0]) |-> (hold_a >= 16'(P_PHY_RST_CYC));
  endproperty
  a_phy_a_hold: assert property (p_phy_a_hold) else $error("port A reset too short");

  property p_phy_b_hold;
    $fell(o_phy_rst[1]) |-> (hold_b >= 16'(P_PHY_RST_CYC));
  endproperty
  a_phy_b_hold: assert property (p_phy_b_hold) else $error("port B reset too short");

  property p_ignore_set;
    (s_reg.phy_rst[0] && wr_rst && !i_wdata[BIT_PORT_A_RST]
      && s_reg.phy_cnt[0] != CW'(P_PHY_RST_CYC - 1)) |=> s_reg.phy_rst[0];
  endproperty
  a_ignore_set: assert property (p_ignore_set) else $error("write altered set bit");

  property p_core_clear;
    (s_reg.core_rst && !s_reg.dig_rst) ##1 !s_reg.core_rst |-> $past(i_core_ready);
  endproperty
  a_core_clear: assert property (p_core_clear) else $error("core bit cleared early");

  property p_core_seq;
    s_core_write ##1 s_reg.core_rst |-> o_core_rst;
  endproperty
  a_core_seq: assert property (p_core_seq) else $error("core reset not driven");

  property p_dig_reload;
    $fell(o_digital_rst) |-> o_eeprom_reload && !o_strap_latch;
  endproperty
  a_dig_reload: assert property (p_dig_reload) else $error("no reload after reset");

  property p_wake_latch;
    (s_reg.wake_sts[0] && !(wr_pm && i_wdata[BIT_AUTO_WAKE_ENABLE_STS]) && !s_reg.dig_rst)
      |=> s_reg.wake_sts[0];
  endproperty
  a_wake_latch: assert property (p_wake_latch) else $error("wake status lost");

  property p_wake_set;
    phy_int[1] && !s_reg.dig_rst |=> s_reg.wake_sts[1];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake status not set");

  property p_wake_irq;
    (s_reg.wake_sts[0] && s_reg.wake_en[0] && s_reg.int_en[BIT_INT_WAKE]) |=> o_irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq missing");

  property p_wake_no_en;
    (s_reg.wake_sts[1] && s_reg.wake_en[1] && i_rd && i_addr == OFS_INT_STATUS)
      |=> o_rdata[BIT_INT_WAKE];
  endproperty
  a_wake_no_en: assert property (p_wake_no_en) else $error("wake status gated");

  property p_auto_wake;
    (s_reg.auto_wake && wake_evt && i_low_power) |=> o_wake_request;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("auto wake missing");

  property p_edpd_now;
    (!s_reg.phy_rst[1] && s_reg.phy_ctl[1][BIT_PC_EDPD_EN] && !s_reg.edpd_prev[1]
      && i_energy_present[1]) |=> s_reg.src_flg[1][FLG_ENERGY] || s_reg.phy_rst[1];
  endproperty
  a_edpd_now: assert property (p_edpd_now) else $error("energy not seen at once");

  property p_rst_read;
    (i_rd && i_addr == OFS_SOFTWARE_RESET_CONTROL) |=> o_rdata[BIT_PORT_A_RST] == $past(o_phy_rst[0])
      && o_rdata[31:7] == 25'h0;
  endproperty
  a_rst_read: assert property (p_rst_read) else $error("reset control read wrong");

  property p_other_irq;
    (i_other_irq && s_reg.int_en[BIT_INT_OTHER]) |=> o_irq;
  endproperty
  a_other_irq: assert property (p_other_irq) else $error("other irq missing");

  property p_dig_clear;
    s_reg.dig_rst |=> (s_reg.int_en == 32'h0000_0000) && (s_reg.wake_sts == 2'b00);
  endproperty
  a_dig_clear: assert property (p_dig_clear) else $error("digital reset kept state");

  property p_wol_flag;
    (!s_reg.phy_rst[0] && |(i_wol_match[3:0] & s_reg.phy_ctl[0][BIT_PC_WOL_TYPES +: 4]))
      |=> s_reg.src_flg[0][FLG_WOL];
  endproperty
  a_wol_flag: assert property (p_wol_flag) else $error("wake frame flag missing");

  property p_edpd_wake;
    (!s_reg.phy_rst[1] && s_reg.phy_pd[1] && s_reg.edpd_prev[1] && i_energy_present[1]
      && s_reg.phy_ctl[1][BIT_PC_EDPD_EN])
      |=> !o_phy_powered_down[1] && s_reg.src_flg[1][FLG_ENERGY];
  endproperty
  a_edpd_wake: assert property (p_edpd_wake) else $error("no resume on energy");

endmodule

/* verif/rcw_core_model.sv */
// Behavioural protocol core: reports ready a while after its reset is released
module rcw_core_model #(
  parameter int READY_DLY = 30
) (
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_core_rst,
  output logic      o_core_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt;

  // Ready drops while held in reset; a slow boot keeps the self-clearing bit visible
  always @(posedge i_core_clk) begin
    if (i_srst || i_core_rst) begin
      cnt <= 0;
      o_core_ready <= 1'b0;
    end else begin
      if (cnt < READY_DLY) cnt <= cnt + 1;
      o_core_ready <= (cnt >= READY_DLY);
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the reset control and wake notification block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcw_pkg::*;

  localparam int P = 20;
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_low_power = 1'b0;
  logic        i_other_irq = 1'b0;
  logic [1:0]  i_energy_present = 2'h0;
  logic [7:0]  i_wol_match = 8'h00;
  logic [1:0]  i_phy_event = 2'h0;
  logic        core_ready, o_core_rst, o_digital_rst, o_eeprom_reload, o_strap_latch;
  logic        o_core_clk_en, o_wake_request, o_irq;
  logic [1:0]  o_phy_rst, o_phy_powered_down;
  logic [31:0] o_rdata, d;
  logic [7:0]  seed = 8'h26;
  logic [3:0]  t, m;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          run [6] = '{default: 0};

  always #5 i_core_clk = ~i_core_clk;

  rcw_top #(.P_PHY_RST_CYC(P)) uut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_core_ready(core_ready), .i_low_power(i_low_power), .i_other_irq(i_other_irq),
    .i_energy_present(i_energy_present), .i_wol_match(i_wol_match),
    .i_phy_event(i_phy_event), .o_core_rst(o_core_rst), .o_phy_rst(o_phy_rst),
    .o_digital_rst(o_digital_rst), .o_eeprom_reload(o_eeprom_reload),
    .o_strap_latch(o_strap_latch), .o_phy_powered_down(o_phy_powered_down),
    .o_core_clk_en(o_core_clk_en), .o_wake_request(o_wake_request), .o_irq(o_irq));

  rcw_core_model #(.READY_DLY(30)) core (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_core_rst(o_core_rst), .o_core_ready(core_ready));

  // Pick one of the watched reset and pulse outputs
  function automatic logic sel(int k);
    case (k)
      0: return o_phy_rst[0];
      1: return o_phy_rst[1];
      2: return o_core_rst;
      3: return o_digital_rst;
      4: return o_eeprom_reload;
      default: return o_strap_latch;
    endcase
  endfunction

  // Count high cycles of each watched output; the test zeroes each count before use except the strap count run[5]
  always @(posedge i_core_clk) begin
    for (int k = 0; k < 6; k++) if (sel(k) === 1'b1) run[k] <= run[k] + 1;
  end

  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Wake-on-LAN flag lands in bit 1 of the port A flag field
  function automatic logic [31:0] exp_wol(logic [3:0] types, logic [3:0] match);
    return {30'h0, |(types & match), 1'b0};
  endfunction

  task automatic summarize();
    $display("Counts: %0d compared, %0d mismatched", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] seen, logic [31:0] exp, string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(logic [11:0] a, logic [31:0] exp, logic [31:0] msk, string what);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(d & msk, exp, what);
  endtask

  // Bounded wait for a watched output to drop
  task automatic wait_low(int k);
    int n;
    n = 0;
    #1;
    while (sel(k) !== 1'b0 && n < 20000) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    if (n >= 20000) begin
      chk(1, 0, "timeout on reset output");
      summarize();
    end
  endtask

  task automatic pulse_wol(logic [7:0] v);
    i_wol_match <= v;
    @(posedge i_core_clk);
    i_wol_match <= 8'h00;
  endtask

  initial begin
    // No host reads while reset holds; data read then would not be trusted
    repeat (10) @(posedge i_core_clk);
    i_srst <= 1'b0;
    // Reset values, strap pulse once, unmapped place reads zero and ignores writes
    cyc(3);
    chk(run[5], 1, "strap pulse after reset");
    chk(o_core_clk_en, 1, "clock enable at reset");
    rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 32'hFFFF_FFFF, "software_reset_control default");
    rchk(OFS_PWR_MGMT, 0, 32'hFFFF_FFFE, "pm default");
    rchk(OFS_INT_STATUS, 0, 32'hFFFF_FFFF, "status default");
    wr(12'h3FC, 32'hFFFF_FFFF);
    rchk(12'h3FC, 0, 32'hFFFF_FFFF, "unmapped read");
    rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 32'hFFFF_FFFF, "unmapped write");
    $display("test reset_values done");

    // PHY resets: held exactly P cycles, re-writes and zero writes ignored
    for (int p = 0; p < 2; p++) begin
      run[p] = 0;
      run[1-p] = 0;
      wr(OFS_SOFTWARE_RESET_CONTROL, 32'h1 << (p + 1));
      wr(OFS_SOFTWARE_RESET_CONTROL, 32'h0);
      rchk(OFS_SOFTWARE_RESET_CONTROL, 32'h1 << (p + 1), 32'hFF, "phy bit while held");
      wr(OFS_SOFTWARE_RESET_CONTROL, 32'h1 << (p + 1));
      wait_low(p);
      chk(run[p], P, "phy reset length");
      chk(run[1-p], 0, "other phy untouched");
      rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 32'hFF, "phy bit self-cleared");
    end
    $display("test phy_reset done");

    // Core reset: bit stays until the core reports ready, writes meanwhile ignored
    run[2] = 0;
    wr(OFS_SOFTWARE_RESET_CONTROL, 32'h40);
    wait_low(2);
    chk(run[2], CORE_RST_CYC, "core reset length");
    rchk(OFS_SOFTWARE_RESET_CONTROL, 32'h40, 32'hFF, "core bit until ready");
    wr(OFS_SOFTWARE_RESET_CONTROL, 32'h40);
    for (int n = 0; n < 60 && d !== 32'h0; n++) rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 0, "poll");
    rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 32'hFF, "core bit cleared");
    chk(run[2], CORE_RST_CYC, "no second core reset");
    $display("test core_reset done");

    // Digital reset: readable while active, clears enables, keeps protected bits
    wr(OFS_INT_ENABLE, 32'h0002_0000);
    wr(OFS_PWR_MGMT, 32'h4);
    run[3] = 0;
    run[4] = 0;
    run[0] = 0;
    wr(OFS_SOFTWARE_RESET_CONTROL, 32'h1);
    rchk(OFS_SOFTWARE_RESET_CONTROL, 32'h1, 32'hFF, "digital bit readable");
    wait_low(3);
    cyc(2);
    chk(run[3], DIG_RST_CYC, "digital reset length");
    chk(run[4], 1, "eeprom reload pulse");
    chk(run[5], 1, "straps not relatched");
    chk(run[0], 0, "phy untouched by digital");
    rchk(OFS_SOFTWARE_RESET_CONTROL, 0, 32'hFF, "digital bit cleared");
    rchk(OFS_INT_ENABLE, 0, 32'hFFFF_FFFF, "enable cleared");
    rchk(OFS_PWR_MGMT, 32'h4, 32'hFE, "protected wake enable");
    $display("test digital_reset done");

    // Random frame types against random matches, flags masked
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      t = seed[3:0];
      seed = lfsr_next(seed);
      m = (i == 0) ? 4'hF : seed[3:0];
      wr(OFS_PHY_CTL, {28'h0, t});
      pulse_wol({4'h0, m});
      cyc(2);
      rchk(OFS_PHY_FLAGS, exp_wol(t, m), 32'h7, "wol flag");
      rchk(OFS_INT_STATUS, 0, 32'hFFFF_FFFF, "masked phy irq");
      wr(OFS_PHY_FLAGS, 32'h7);
    end
    $display("test wol_random done");

    // Wake path port A: latch, enable gating, irq enable, write-one clear
    wr(OFS_PHY_CTL, 32'h4F);
    wr(OFS_INT_ENABLE, 32'h0);
    pulse_wol(8'h04);
    cyc(3);
    rchk(OFS_INT_STATUS, 32'h0402_0000, 32'hFFFF_FFFF, "phy a and wake");
    chk(o_irq, 0, "irq disabled");
    rchk(OFS_PWR_MGMT, 32'h14, 32'h3E, "wake status latched");
    wr(OFS_INT_ENABLE, 32'h0002_0000);
    cyc(2);
    chk(o_irq, 1, "wake irq");
    wr(OFS_PHY_FLAGS, 32'h7);
    cyc(2);
    rchk(OFS_PWR_MGMT, 32'h14, 32'h3E, "status held until cleared");
    wr(OFS_PWR_MGMT, 32'h14);
    cyc(2);
    rchk(OFS_PWR_MGMT, 32'h04, 32'h3E, "status cleared");
    rchk(OFS_INT_STATUS, 0, 32'hFFFF_FFFF, "status idle");
    chk(o_irq, 0, "irq released");
    wr(OFS_INT_ENABLE, 32'h1);
    i_other_irq <= 1'b1;
    cyc(3);
    chk(o_irq, 1, "other irq");
    i_other_irq <= 1'b0;
    $display("test wake_port_a done");

    // Port B: energy already present when power-down is enabled, then other event
    i_energy_present <= 2'b10;
    wr(OFS_PHY_CTL, 32'h0000_B000);
    cyc(3);
    rchk(OFS_PHY_FLAGS, 32'h100, 32'h700, "energy at once");
    i_phy_event <= 2'b10;
    @(posedge i_core_clk);
    i_phy_event <= 2'b00;
    cyc(3);
    rchk(OFS_PHY_FLAGS, 32'h500, 32'h700, "other event flag");
    rchk(OFS_INT_STATUS, 32'h0800_0000, 32'hFFFF_FFFF, "phy b irq");
    rchk(OFS_PWR_MGMT, 32'h20, 32'h20, "port b status");
    // Energy gone: port B powers down; energy back resumes it and flags again
    i_energy_present <= 2'b00;
    cyc(3);
    chk(o_phy_powered_down, 2'b10, "power-down without energy");
    wr(OFS_PHY_FLAGS, 32'h100);
    i_energy_present <= 2'b10;
    cyc(3);
    chk(o_phy_powered_down, 2'b00, "resumed on energy");
    rchk(OFS_PHY_FLAGS, 32'h500, 32'h700, "energy flag again");
    $display("test energy_port_b done");

    // Auto-wake from low power, ready forced low, clock gating
    wr(OFS_PWR_MGMT, 32'h0A);
    i_low_power <= 1'b1;
    cyc(3);
    chk(o_wake_request, 1, "auto wake");
    rchk(OFS_PWR_MGMT, 32'h2A, 32'h3F, "pm read in low power");
    rchk(OFS_INT_STATUS, 32'h0802_0000, 32'hFFFF_FFFF, "wake status, irq off");
    wr(OFS_PWR_MGMT, 32'h08);
    cyc(2);
    chk(o_wake_request, 0, "auto wake off");
    i_low_power <= 1'b0;
    wr(OFS_PWR_MGMT, 32'h48);
    cyc(2);
    chk(o_core_clk_en, 0, "core clock gated");
    rchk(OFS_PHY_FLAGS, 32'h500, 32'h700, "state kept while gated");
    wr(OFS_PWR_MGMT, 32'h08);
    cyc(2);
    chk(o_core_clk_en, 1, "core clock back");
    $display("test power done");
    summarize();
  end
endmodule
